// file: ah_pkg.sv
// Package for the anti-hunt supervisor: register map, resets, states and carriers
package ah_pkg;

  // ==========================================================
  // Register map (byte addresses)
  localparam logic [7:0] AH_THRESH_OFS = 8'h00;
  localparam logic [7:0] AH_DELAY_OFS = 8'h04;
  localparam logic [7:0] AH_MODE_OFS = 8'h08;
  localparam logic [7:0] AH_TORQUE_OFS = 8'h0C;
  localparam logic [7:0] AH_STATUS_OFS = 8'h10;

  // ==========================================================
  // Host command codes for the threshold and delay writes; the register slave never uses them
  localparam logic [7:0] AH_THRESH_CMD_CODE = 8'h96;
  localparam logic [7:0] AH_DELAY_CMD_CODE = 8'hE6;

  // ==========================================================
  // Reset values
  localparam logic [15:0] AH_DELAY_RST = 16'h04E2;
  localparam logic [15:0] AH_OTC_RST = 16'h0000;
  localparam logic [15:0] AH_CTO_RST = 16'h0000;
  localparam logic [15:0] AH_TORQUE_RST = 16'h0000;

  // ==========================================================
  // Timing: one delay tick is 120 us at a 40 ns clock
  localparam int AH_TICK_US = 120;
  localparam int AH_CLK_PERIOD_NS = 40;
  localparam int AH_TICK_CYCLES = (AH_TICK_US * 1000) / AH_CLK_PERIOD_NS;

  // ==========================================================
  // Loop states, Gray along closed -> settle -> open
  typedef enum logic [1:0] {
    AH_CLOSED = 2'b00,
    AH_SETTLE = 2'b01,
    AH_OPEN = 2'b11
  } ah_state_e;

  // Inputs from the position loop and motor drive
  typedef struct packed {
    logic in_motion;
    logic [15:0] pos_error;
    logic [15:0] torque_cmd;
  } ah_loop_in_s;

  // Status back to the loop
  typedef struct packed {
    logic open_loop;
    logic settling;
  } ah_loop_out_s;

endpackage

// file: ah_tick_gen.sv
// Delay tick generator: one-cycle pulse every DIV clocks
`timescale 1ns/1ps
`default_nettype none
module ah_tick_gen import ah_pkg::*; #(
  parameter int DIV = AH_TICK_CYCLES
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Tick out
  output logic tick
);

  logic [15:0] cnt_reg;
  logic [15:0] cnt_next;
  logic tick_reg;
  logic tick_next;

  // Next count and tick
  always_comb begin
    if (cnt_reg == 16'(DIV - 1)) begin
      cnt_next = 16'h0000;
      tick_next = 1'b1;
    end else begin
      cnt_next = cnt_reg + 16'h0001;
      tick_next = 1'b0;
    end
  end

  // Register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_reg <= 16'h0000;
      tick_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      tick_reg <= tick_next;
    end
  end

  assign tick = tick_reg;

endmodule
`default_nettype wire

// file: ah_supervisor.sv
// Anti-hunt supervisor with AHB-Lite register slave
// Notes on behaviour
// - In open loop, error above open-to-closed threshold returns to closed loop.
// - Entry to open loop only while error is within closed-to-open threshold.
// - Non-negative closed-to-open threshold also needs torque below holding torque.
// - Negative closed-to-open threshold skips the torque check on entry.
// - Both open-loop torque limits zero make thresholds a plain dead-band.
// - Entry waits the settle delay after all conditions hold.
// - Delay is 16-bit count of 120 us ticks, 1250 after reset.
// - Default mode: motion forces closed loop until motion ends and delay passes.
// - Mode 1 ignores motion; mode 0 restores default behaviour.
`timescale 1ns/1ps
`default_nettype none
module ah_supervisor import ah_pkg::*; (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Position loop
  input wire ah_loop_in_s loop_in,
  output ah_loop_out_s loop_out
);

  // ==========================================================
  // Register file and bus slave
  logic [15:0] otc_reg, otc_next;
  logic [15:0] cto_reg, cto_next;
  logic [15:0] delay_reg, delay_next;
  logic mode_reg, mode_next;
  logic [15:0] hold_tq_reg, hold_tq_next;
  logic [15:0] move_tq_reg, move_tq_next;
  logic dp_wr_reg, dp_wr_next;
  logic dp_rd_reg, dp_rd_next;
  logic [7:0] dp_addr_reg, dp_addr_next;
  ah_state_e state_reg, state_next;
  logic [15:0] cnt_reg, cnt_next;
  logic tick;
  logic addr_ok;

  assign addr_ok = hsel && htrans[1] && hready;
  assign hreadyout = 1'b1; // Zero wait states
  assign hresp = 1'b0; // Always OKAY

  // Address phase capture and register writes in the data phase
  always_comb begin
    dp_wr_next = addr_ok && hwrite;
    dp_rd_next = addr_ok && !hwrite;
    dp_addr_next = addr_ok ? haddr[7:0] : dp_addr_reg;
    otc_next = otc_reg;
    cto_next = cto_reg;
    delay_next = delay_reg;
    mode_next = mode_reg;
    hold_tq_next = hold_tq_reg;
    move_tq_next = move_tq_reg;
    if (dp_wr_reg) begin
      case (dp_addr_reg)
        AH_THRESH_OFS: begin
          otc_next = hwdata[15:0];
          cto_next = hwdata[31:16];
        end
        AH_DELAY_OFS: delay_next = hwdata[15:0];
        AH_MODE_OFS: mode_next = hwdata[0];
        AH_TORQUE_OFS: begin
          hold_tq_next = hwdata[15:0];
          move_tq_next = hwdata[31:16];
        end
        default: ;
      endcase
    end
  end

  // Register the bus and configuration state
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_wr_reg <= 1'b0;
      dp_rd_reg <= 1'b0;
      dp_addr_reg <= 8'h00;
      otc_reg <= AH_OTC_RST;
      cto_reg <= AH_CTO_RST;
      delay_reg <= AH_DELAY_RST;
      mode_reg <= 1'b0;
      hold_tq_reg <= AH_TORQUE_RST;
      move_tq_reg <= AH_TORQUE_RST;
    end else begin
      dp_wr_reg <= dp_wr_next;
      dp_rd_reg <= dp_rd_next;
      dp_addr_reg <= dp_addr_next;
      otc_reg <= otc_next;
      cto_reg <= cto_next;
      delay_reg <= delay_next;
      mode_reg <= mode_next;
      hold_tq_reg <= hold_tq_next;
      move_tq_reg <= move_tq_next;
    end
  end

  // Read mux over register flops during the data phase
  always_comb begin
    hrdata = 32'h0000_0000;
    if (dp_rd_reg) begin
      case (dp_addr_reg)
        AH_THRESH_OFS: hrdata = {cto_reg, otc_reg};
        AH_DELAY_OFS: hrdata = {16'h0000, delay_reg};
        AH_MODE_OFS: hrdata = {31'h0000_0000, mode_reg};
        AH_TORQUE_OFS: hrdata = {move_tq_reg, hold_tq_reg};
        AH_STATUS_OFS: hrdata = {cnt_reg, 14'h0000, state_reg};
        default: hrdata = 32'h0000_0000;
      endcase
    end
  end

  // ==========================================================
  // Entry and exit conditions
  logic [16:0] err_mag;
  logic [16:0] tq_mag;
  logic [16:0] entry_lim;
  logic cto_neg, deadband, err_ok, torque_ok, motion_ok, entry_ok, exit_req;

  // Magnitudes of error, torque and the entry threshold
  assign err_mag = loop_in.pos_error[15] ? 17'(-$signed({1'b1, loop_in.pos_error}))
                                         : {1'b0, loop_in.pos_error};
  assign tq_mag = loop_in.torque_cmd[15] ? 17'(-$signed({1'b1, loop_in.torque_cmd}))
                                         : {1'b0, loop_in.torque_cmd};
  assign cto_neg = cto_reg[15];
  assign entry_lim = cto_neg ? 17'(-$signed({1'b1, cto_reg})) : {1'b0, cto_reg};
  assign deadband = (hold_tq_reg == 16'h0000) && (move_tq_reg == 16'h0000);
  assign err_ok = err_mag <= entry_lim;
  assign torque_ok = cto_neg || deadband || (tq_mag < {1'b0, hold_tq_reg});
  assign motion_ok = mode_reg || !loop_in.in_motion;
  assign entry_ok = err_ok && torque_ok && motion_ok;
  // exit on large error or motion in default mode
  assign exit_req = (err_mag > {1'b0, otc_reg}) || (!mode_reg && loop_in.in_motion);

  ah_tick_gen #(
    .DIV(AH_TICK_CYCLES)
  ) u_tick (
    .hclk(hclk),
    .hresetn(hresetn),
    .tick(tick)
  );

  // ==========================================================
  // Loop mode state machine
  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    case (state_reg)
      AH_CLOSED: begin
        cnt_next = 16'h0000;
        if (entry_ok) begin
          state_next = AH_SETTLE;
        end
      end
      AH_SETTLE: begin
        if (!entry_ok) begin
          state_next = AH_CLOSED;
          cnt_next = 16'h0000;
        end else if (cnt_reg >= delay_reg) begin
          state_next = AH_OPEN;
          cnt_next = 16'h0000;
        end else if (tick) begin
          cnt_next = cnt_reg + 16'h0001;
        end
      end
      AH_OPEN: begin
        if (exit_req) begin
          state_next = AH_CLOSED;
        end
      end
      default: begin
        state_next = AH_CLOSED;
        cnt_next = 16'h0000;
      end
    endcase
  end

  // Register the state machine
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_reg <= AH_CLOSED;
      cnt_reg <= 16'h0000;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
    end
  end

  // One driver for the whole status carrier
  assign loop_out = '{open_loop: (state_reg == AH_OPEN), settling: (state_reg == AH_SETTLE)};

  // ==========================================================
  // Assertions
  property p_exit_on_error;
    @(posedge hclk) disable iff (!hresetn)
    (state_reg == AH_OPEN && err_mag > {1'b0, otc_reg}) |=> state_reg == AH_CLOSED;
  endproperty
  a_exit_on_error: assert property (p_exit_on_error) else $error("open loop kept on big error");

  property p_entry_err;
    @(posedge hclk) disable iff (!hresetn)
    (state_reg == AH_SETTLE && state_next == AH_OPEN) |-> err_mag <= entry_lim;
  endproperty
  a_entry_err: assert property (p_entry_err) else $error("entered open loop outside limit");

  property p_entry_torque;
    @(posedge hclk) disable iff (!hresetn)
    (state_reg == AH_SETTLE && state_next == AH_OPEN && !cto_neg && !deadband)
      |-> tq_mag < {1'b0, hold_tq_reg};
  endproperty
  a_entry_torque: assert property (p_entry_torque) else $error("entered with high torque");

  property p_skip_torque;
    @(posedge hclk) disable iff (!hresetn)
    (state_reg == AH_CLOSED && cto_neg && err_ok && motion_ok) |=> state_reg == AH_SETTLE;
  endproperty
  a_skip_torque: assert property (p_skip_torque) else $error("torque not skipped");

  property p_deadband;
    @(posedge hclk) disable iff (!hresetn)
    (state_reg == AH_CLOSED && deadband && err_ok && motion_ok) |=> state_reg == AH_SETTLE;
  endproperty
  a_deadband: assert property (p_deadband) else $error("dead-band entry refused");

  property p_delay_wait;
    @(posedge hclk) disable iff (!hresetn)
    (state_reg == AH_SETTLE && cnt_reg < delay_reg) |=> state_reg != AH_OPEN;
  endproperty
  a_delay_wait: assert property (p_delay_wait) else $error("open before delay");

  property p_tick_count;
    @(posedge hclk) disable iff (!hresetn)
    (state_reg == AH_SETTLE && entry_ok && !tick && cnt_reg < delay_reg) |=> $stable(cnt_reg);
  endproperty
  a_tick_count: assert property (p_tick_count) else $error("count moved without tick");

  property p_motion_closed;
    @(posedge hclk) disable iff (!hresetn)
    (!mode_reg && loop_in.in_motion) |=> state_reg != AH_OPEN;
  endproperty
  a_motion_closed: assert property (p_motion_closed) else $error("open during motion");

  property p_mode1_stay;
    @(posedge hclk) disable iff (!hresetn)
    (mode_reg && state_reg == AH_OPEN && err_mag <= {1'b0, otc_reg}) |=> state_reg == AH_OPEN;
  endproperty
  a_mode1_stay: assert property (p_mode1_stay) else $error("mode 1 left open loop");

  property p_lapse_restart;
    @(posedge hclk) disable iff (!hresetn)
    (state_reg == AH_SETTLE && !entry_ok) |=> (state_reg == AH_CLOSED && cnt_reg == 16'h0000);
  endproperty
  a_lapse_restart: assert property (p_lapse_restart) else $error("lapse kept count");

  c_enter_open: cover property (@(posedge hclk) disable iff (!hresetn)
    state_reg == AH_SETTLE ##1 state_reg == AH_OPEN);
  c_exit_open: cover property (@(posedge hclk) disable iff (!hresetn)
    state_reg == AH_OPEN ##1 state_reg == AH_CLOSED);
  c_settle_abort: cover property (@(posedge hclk) disable iff (!hresetn)
    state_reg == AH_SETTLE && cnt_reg != 16'h0000 ##1 state_reg == AH_CLOSED);

endmodule
`default_nettype wire

// file: ah_loop_model.sv
// Behavioural position loop and motor drive feeding the anti-hunt supervisor
`timescale 1ns/1ps
`default_nettype none
module ah_loop_model import ah_pkg::*; (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Requested loop condition
  input wire logic motion,
  input wire logic [15:0] err,
  input wire logic [15:0] trq,
  // Levels to the supervisor
  output ah_loop_in_s loop_in
);
  // Registered levels; reports motion during reset, as a loop still settling would
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      loop_in <= '{in_motion: 1'b1, pos_error: 16'h0000, torque_cmd: 16'h0000};
    end else begin
      loop_in <= '{in_motion: motion, pos_error: err, torque_cmd: trq};
    end
  end
endmodule
`default_nettype wire

// file: testbench.sv
// Self-checking testbench for the anti-hunt supervisor
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin tests_run++; if ((got) !== (exp)) begin failures++; \
  $display("[FAIL] %0t: mismatch got %h expected %h", $time, got, exp); end end
module testbench import ah_pkg::*;;
  logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, motion;
  logic [31:0] haddr, hwdata, hrdata, rdata;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [15:0] err, trq;
  ah_loop_in_s loop_in;
  ah_loop_out_s loop_out;
  int failures, tests_run, cycles;

  // ==========================================================
  // Clock, bus ready loop and instances
  always #20 hclk = ~hclk;
  assign hready = hreadyout;
  ah_supervisor dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .loop_in(loop_in),
    .loop_out(loop_out));
  ah_loop_model loop (.hclk(hclk), .hresetn(hresetn), .motion(motion), .err(err), .trq(trq),
    .loop_in(loop_in));

  // ==========================================================
  // Verdict and run end
  task automatic close_out();
    $display("Comparisons %0d, mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Hang guard
  always @(posedge hclk) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      close_out();
    end
  end

  // One AHB-Lite single transfer; read data lands in rdata
  // Waits on hready without a limit of its own; the hang guard ends a stuck wait
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h00_0000, a};
    htrans <= 2'b10;
    hwrite <= wr;
    do begin @(posedge hclk); end while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do begin @(posedge hclk); end while (hready !== 1'b1);
    rdata = hrdata;
  endtask

  // Sets the loop condition the model presents
  task automatic set_loop(input logic m, input logic [15:0] e, input logic [15:0] t);
    @(posedge hclk);
    motion <= m;
    err <= e;
    trq <= t;
  endtask

  // Waits a bounded time for {open_loop, settling}, then compares
  task automatic wait_out(input logic [1:0] exp, input int lim);
    int i;
    i = 0;
    while (loop_out !== exp && i < lim) begin @(posedge hclk); i++; end
    `CHK(loop_out, exp)
  endtask

  // Waits a number of cycles, then compares once
  task automatic hold_out(input logic [1:0] exp, input int n);
    repeat (n) @(posedge hclk);
    `CHK(loop_out, exp)
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    {hclk, hsel, hwrite, htrans, haddr, hwdata, err, trq} = '0;
    {failures, tests_run, cycles} = '0;
    hsize = 3'b010;
    motion = 1'b1;
    hresetn = 1'b0;
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    ahb(1'b0, AH_DELAY_OFS, 32'h0000_0000);
    `CHK(rdata, 32'h0000_04E2)
    `CHK(hresp, 1'b0)
    ahb(1'b0, AH_THRESH_OFS, 32'h0000_0000);
    `CHK(rdata, 32'h0000_0000)
    ahb(1'b0, 8'h20, 32'h0000_0000);
    `CHK(rdata, 32'h0000_0000)
    ahb(1'b1, AH_THRESH_OFS, 32'h0004_000A);
    ahb(1'b0, AH_THRESH_OFS, 32'h0000_0000);
    `CHK(rdata, 32'h0004_000A)
    ahb(1'b1, AH_DELAY_OFS, 32'h0000_FFFF);
    ahb(1'b0, AH_DELAY_OFS, 32'h0000_0000);
    `CHK(rdata, 32'h0000_FFFF)
    ahb(1'b1, AH_DELAY_OFS, 32'h0000_0000);
    ahb(1'b1, AH_TORQUE_OFS, 32'h0000_0064);
    set_loop(1'b0, 16'h0003, 16'h00C8);
    hold_out(2'b00, 10);
    set_loop(1'b0, 16'h0003, 16'h0032);
    wait_out(2'b10, 6);
    set_loop(1'b0, 16'h000A, 16'h0032);
    hold_out(2'b10, 5);
    set_loop(1'b0, 16'h000B, 16'h0032);
    wait_out(2'b00, 3);
    set_loop(1'b0, 16'h0003, 16'h0032);
    wait_out(2'b10, 6);
    set_loop(1'b1, 16'h0003, 16'h0032);
    wait_out(2'b00, 3);
    hold_out(2'b00, 10);
    ahb(1'b1, AH_MODE_OFS, 32'h0000_0001);
    wait_out(2'b10, 6);
    ahb(1'b1, AH_MODE_OFS, 32'h0000_0000);
    wait_out(2'b00, 4);
    ahb(1'b1, AH_THRESH_OFS, 32'hFFFB_000A);
    set_loop(1'b0, 16'hFFFB, 16'h00C8);
    wait_out(2'b10, 6);
    set_loop(1'b0, 16'h000B, 16'h00C8);
    wait_out(2'b00, 3);
    set_loop(1'b0, 16'hFFFA, 16'h00C8);
    hold_out(2'b00, 10);
    ahb(1'b1, AH_TORQUE_OFS, 32'h0000_0000);
    ahb(1'b1, AH_THRESH_OFS, 32'h0004_000A);
    set_loop(1'b0, 16'h0004, 16'h00C8);
    wait_out(2'b10, 6);
    // Error must pass the open-to-closed threshold of 10 to leave open loop
    set_loop(1'b0, 16'h000B, 16'h00C8);
    wait_out(2'b00, 3);
    hold_out(2'b00, 10);
    ahb(1'b1, AH_DELAY_OFS, 32'h0000_0002);
    set_loop(1'b0, 16'h0003, 16'h00C8);
    wait_out(2'b01, 4);
    ahb(1'b0, AH_STATUS_OFS, 32'h0000_0000);
    `CHK(rdata[1:0], 2'b01)
    repeat (2000) @(posedge hclk);
    set_loop(1'b0, 16'h0005, 16'h00C8);
    wait_out(2'b00, 3);
    set_loop(1'b0, 16'h0003, 16'h00C8);
    wait_out(2'b01, 4);
    hold_out(2'b01, 2900);
    wait_out(2'b10, 7000);
    close_out();
  end
endmodule
`default_nettype wire
